// [ivf_framer.sv]
// isochronous video packet framer top
// Operation
// - length field holds payload byte count
// - tag field always zero
// - channel is last programmed channel
// - tcode is isochronous block code
// - sync 0001h on frame's first block
// - payload carries current frame video
// - sizes counted in four-byte quadlets
// - combination streams only at required speed or faster
// - per-period quadlets follow selected mode
// - partial format size agreed at runtime
`timescale 1ns/1ps
module ivf_framer #(
  parameter int PKTQ_W = 13
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ivf_pkg::CHAN_W-1:0] iso_channel,
  input wire logic [ivf_pkg::SPD_W-1:0] bus_speed,
  input wire logic [ivf_pkg::SPD_W-1:0] need_speed,
  input wire logic [PKTQ_W-1:0] pkt_quads,
  input wire logic start,
  input wire logic frame_first,
  output logic start_ready,
  output logic speed_err,
  input wire logic vid_valid,
  output logic vid_ready,
  input wire logic [ivf_pkg::QUAD_W-1:0] vid_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [ivf_pkg::QUAD_W-1:0] tx_data,
  output logic tx_last
);
  import ivf_pkg::*;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  ivf_state_t st_q, st_d;
  logic [PKTQ_W-1:0] left_q, left_d;
  logic [31:0] crc_q, crc_d;
  logic [31:0] hdr_q, hdr_d;
  logic start_ready_q, speed_err_q, speed_err_d;
  logic b_valid, b_ready, b_last, b_push;
  logic [31:0] b_data;
  logic o_valid, o_last;
  logic [31:0] o_data;
  logic speed_ok;

  assign speed_ok = (bus_speed >= need_speed);
  assign b_push = b_valid && b_ready;

  always_comb begin
    st_d = st_q;
    left_d = left_q;
    crc_d = crc_q;
    hdr_d = hdr_q;
    speed_err_d = speed_err_q;
    b_valid = 1'b0;
    b_data = '0;
    b_last = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          speed_err_d = !speed_ok;
          if (speed_ok && pkt_quads != '0) begin
            left_d = pkt_quads;
            hdr_d = '0;
            hdr_d[HDR_LEN_LSB +: LEN_W] =
              LEN_W'({pkt_quads, 2'h0});
            hdr_d[HDR_TAG_LSB +: 2] = TAG_VAL;
            hdr_d[HDR_CHAN_LSB +: CHAN_W] = iso_channel;
            hdr_d[HDR_TCODE_LSB +: 4] = TCODE_ISO_BLOCK;
            hdr_d[HDR_SY_LSB +: 4] = frame_first ? SY_FIRST : SY_OTHER;
            st_d = ST_HDR;
          end
        end
      end
      ST_HDR: begin
        b_valid = 1'b1;
        b_data = hdr_q;
        if (b_ready) begin
          crc_d = ~crc_step(CRC_INIT, hdr_q);
          st_d = ST_HCRC;
        end
      end
      ST_HCRC: begin
        b_valid = 1'b1;
        b_data = crc_q;
        if (b_ready) begin
          crc_d = CRC_INIT;
          st_d = ST_PAY;
        end
      end
      ST_PAY: begin
        b_valid = vid_valid;
        b_data = vid_data;
        if (b_push) begin
          crc_d = crc_step(crc_q, vid_data);
          left_d = left_q - PKTQ_W'(1);
          if (left_q == PKTQ_W'(1)) begin
            st_d = ST_DCRC;
          end
        end
      end
      ST_DCRC: begin
        b_valid = 1'b1;
        b_data = ~crc_q;
        b_last = 1'b1;
        if (b_ready) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // vid_ready is combinational toward the buffer so no word slips
  assign vid_ready = (st_q == ST_PAY) && b_ready;

  ivf_skid #(
    .W(QUAD_W),
    .DEPTH(2)
  ) u_skid (
    .clk(clk),
    .nrst(nrst),
    .in_valid(b_valid),
    .in_ready(b_ready),
    .in_data(b_data),
    .in_last(b_last),
    .out_valid(o_valid),
    .out_ready(tx_ready),
    .out_data(o_data),
    .out_last(o_last)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      left_q <= '0;
      crc_q <= CRC_INIT;
      hdr_q <= '0;
      speed_err_q <= 1'b0;
      start_ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      left_q <= left_d;
      crc_q <= crc_d;
      hdr_q <= hdr_d;
      speed_err_q <= speed_err_d;
      start_ready_q <= (st_d == ST_IDLE);
    end
  end

  assign start_ready = start_ready_q;
  assign speed_err = speed_err_q;
  assign tx_valid = o_valid;
  assign tx_data = o_data;
  assign tx_last = o_last;

  // packet steps, used to build the ordering checks below
  sequence s_hdr_go;
    st_q == ST_IDLE && start && speed_ok && pkt_quads != '0;
  endsequence
  sequence s_refused;
    st_q == ST_IDLE && start && !speed_ok;
  endsequence
  sequence s_hdr_sent;
    st_q == ST_HDR && b_ready;
  endsequence
  sequence s_hcrc_sent;
    st_q == ST_HCRC && b_ready;
  endsequence
  sequence s_last_pay;
    st_q == ST_PAY && b_push && left_q == PKTQ_W'(1);
  endsequence
  sequence s_dcrc_sent;
    st_q == ST_DCRC && b_ready;
  endsequence

  a_hdr_length: assert property (@(posedge clk) disable iff (!nrst)
    s_hdr_go
    |=> hdr_q[31:16] == 16'($past(pkt_quads) * 4))
    else $error("length field not four times quadlet count");

  a_tag_zero: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_HDR
    |-> hdr_q[15:14] == 2'h0)
    else $error("tag field not zero");

  a_chan_copy: assert property (@(posedge clk) disable iff (!nrst)
    s_hdr_go
    |=> hdr_q[13:8] == $past(iso_channel))
    else $error("channel field mismatch");

  a_hdr_stable: assert property (@(posedge clk) disable iff (!nrst)
    st_q != ST_IDLE
    |=> hdr_q == $past(hdr_q))
    else $error("header changed during packet");

  a_tcode_iso: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_HDR
    |-> hdr_q[7:4] == 4'hA)
    else $error("wrong tcode");

  a_sync_first: assert property (@(posedge clk) disable iff (!nrst)
    s_hdr_go
    |=> hdr_q[3:0] == ($past(frame_first) ? 4'h1 : 4'h0))
    else $error("sync field wrong");

  a_pay_pass: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_PAY && b_push
    |-> b_data == vid_data)
    else $error("payload word altered");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_IDLE
    |-> !b_valid)
    else $error("word pushed while idle");

  a_out_hold: assert property (@(posedge clk) disable iff (!nrst)
    tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("stalled output word lost");

  a_pay_count: assert property (@(posedge clk) disable iff (!nrst)
    s_last_pay
    |=> st_q == ST_DCRC)
    else $error("payload quadlet count wrong");

  a_len_hold: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_PAY && !b_push
    |=> st_q == ST_PAY && left_q == $past(left_q))
    else $error("quadlet count moved without a word");

  a_speed_block: assert property (@(posedge clk) disable iff (!nrst)
    s_refused
    |=> st_q == ST_IDLE && speed_err)
    else $error("packet started at too low speed");

  a_speed_clear: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_IDLE && start && speed_ok
    |=> !speed_err)
    else $error("speed error kept on good start");

  a_ready_idle: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst)
    |-> start_ready == (st_q == ST_IDLE))
    else $error("start ready disagrees with idle");

  a_state_onehot: assert property (@(posedge clk) disable iff (!nrst)
    $onehot(st_q))
    else $error("state not one-hot");

  a_zero_refused: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_IDLE && start && pkt_quads == '0
    |=> st_q == ST_IDLE)
    else $error("empty packet started");

  a_hcrc_follow: assert property (@(posedge clk) disable iff (!nrst)
    s_hdr_sent
    |=> st_q == ST_HCRC)
    else $error("header crc not after header");

  a_hcrc_seed: assert property (@(posedge clk) disable iff (!nrst)
    s_hcrc_sent
    |=> st_q == ST_PAY && crc_q == CRC_INIT)
    else $error("data crc not seeded after header crc");

  a_dcrc_last: assert property (@(posedge clk) disable iff (!nrst)
    st_q == ST_DCRC
    |-> b_valid && b_last)
    else $error("data crc not marked last");

  a_last_only: assert property (@(posedge clk) disable iff (!nrst)
    b_valid && b_last
    |-> st_q == ST_DCRC)
    else $error("last mark outside data crc");

  a_dcrc_close: assert property (@(posedge clk) disable iff (!nrst)
    s_dcrc_sent
    |=> st_q == ST_IDLE)
    else $error("framer not idle after data crc");
endmodule

// [ivf_host.sv]
// host adapter model that collects the outgoing isochronous stream
`timescale 1ns/1ps
module ivf_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [31:0] tx_data,
  input wire logic tx_last
);
  logic [31:0] word_q [0:63];
  logic last_q [0:63];
  int cnt = 0;
  initial tx_ready = 1'h0;
  // slow mode stalls every other cycle to exercise the buffer
  always @(negedge clk) tx_ready <= nrst && (!slow || !tx_ready);
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      word_q[cnt] <= tx_data;
      last_q[cnt] <= tx_last;
      cnt <= cnt + 1;
    end
  end
endmodule

// [ivf_pkg.sv]
// package: constants for the isochronous video packet framer
package ivf_pkg;
  localparam int QUAD_W = 32;
  localparam int BYTES_PER_QUAD = 4;
  localparam int LEN_W = 16;
  localparam int CHAN_W = 6;
  localparam int SPD_W = 3;
  localparam int PKTQ_W = 13;
  localparam logic [1:0] TAG_VAL = 2'h0;
  localparam logic [3:0] TCODE_ISO_BLOCK = 4'hA;
  localparam logic [3:0] SY_FIRST = 4'h1;
  localparam logic [3:0] SY_OTHER = 4'h0;
  localparam int HDR_LEN_LSB = 16;
  localparam int HDR_TAG_LSB = 14;
  localparam int HDR_CHAN_LSB = 8;
  localparam int HDR_TCODE_LSB = 4;
  localparam int HDR_SY_LSB = 0;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h1;
  localparam logic [2:0] SPD_S400 = 3'h2;
  localparam logic [2:0] SPD_S800 = 3'h3;
  localparam logic [2:0] SPD_S1600 = 3'h4;
  localparam logic [2:0] SPD_S3200 = 3'h5;
  localparam logic [12:0] MAX_Q_S100 = 13'h0100;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HDR = 5'b00010,
    ST_HCRC = 5'b00100,
    ST_PAY = 5'b01000,
    ST_DCRC = 5'b10000
  } ivf_state_t;
endpackage

// [ivf_skid.sv]
// two-entry buffer between framer and link
`timescale 1ns/1ps
module ivf_skid #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  input wire logic in_last,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic out_last
);
  logic [W:0] mem_q [DEPTH];
  logic [W:0] mem_d [DEPTH];
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;
  assign in_ready = (cnt_q < 2'(DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[0][W-1:0];
  assign out_last = mem_q[0][W];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    if (pop) begin
      mem_d[0] = mem_q[1];
    end
    if (push) begin
      mem_d[(pop ? cnt_q - 2'h1 : cnt_q) == 2'h0 ? 0 : 1] = {in_last, in_data};
    end
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule

// [tb_top.sv]
// self-checking bench for the isochronous video packet framer
`timescale 1ns/1ps
module tb_top;
  import ivf_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, start = 1'h0, frame_first = 1'h0;
  logic vid_valid = 1'h0, slow = 1'h0, tx_ready, r;
  logic [5:0] iso_channel = 6'h00;
  logic [2:0] bus_speed = 3'h0, need_speed = 3'h0;
  logic [12:0] pkt_quads = 13'h0000;
  logic [31:0] vid_data = 32'h0, tx_data;
  logic start_ready, speed_err, vid_ready, tx_valid, tx_last;
  int mismatches = 0, n_compared = 0, cyc = 0;
  always #4 clk = ~clk;
  ivf_framer i_dut (.clk(clk), .nrst(nrst), .iso_channel(iso_channel),
    .bus_speed(bus_speed), .need_speed(need_speed), .pkt_quads(pkt_quads),
    .start(start), .frame_first(frame_first), .start_ready(start_ready),
    .speed_err(speed_err), .vid_valid(vid_valid), .vid_ready(vid_ready),
    .vid_data(vid_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last));
  ivf_host i_host (.clk(clk), .nrst(nrst), .slow(slow), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ceiling well above the fewer than one hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  // msb first, all-ones start, inverted result
  function automatic logic [31:0] crc32(input logic [31:0] w[$]);
    logic [31:0] c;
    logic fb;
    c = CRC_INIT;
    foreach (w[i]) for (int b = 31; b >= 0; b--) begin
      fb = c[31] ^ w[i][b];
      c = {c[30:0], 1'h0};
      if (fb) c = c ^ CRC_POLY;
    end
    return ~c;
  endfunction
  task automatic pulse_start(input logic [2:0] nd, input logic [2:0] bs);
    @(negedge clk);
    need_speed = nd;
    bus_speed = bs;
    start = 1'h1;
    @(negedge clk);
    start = 1'h0;
  endtask
  task automatic t_reset;
    cmp({start_ready, tx_valid, speed_err}, 3'h4);
    $display("reset test done");
  endtask
  task automatic run_pkt(input logic [5:0] ch, input logic ff, input int nq,
    input logic sl, input logic [2:0] nd, input logic [2:0] bs);
    logic [31:0] pay[$];
    logic [31:0] hq[$];
    logic [31:0] hdr;
    int b;
    b = i_host.cnt;
    slow = sl;
    for (int k = 0; k < nq; k++) pay.push_back(32'h5A5A0000 + k * 7 + ch);
    iso_channel = ch;
    frame_first = ff;
    pkt_quads = nq[12:0];
    pulse_start(nd, bs);
    iso_channel = ~ch;
    foreach (pay[k]) begin
      @(negedge clk);
      vid_valid = 1'h1;
      vid_data = pay[k];
      forever begin
        #3;
        r = vid_ready;
        @(posedge clk);
        if (r) break;
      end
    end
    @(negedge clk);
    vid_valid = 1'h0;
    for (int i = 0; i < 200 && i_host.cnt < b + nq + 3; i++) @(negedge clk);
    hdr = {16'(nq * 4), TAG_VAL, ch, TCODE_ISO_BLOCK, ff ? SY_FIRST : SY_OTHER};
    hq = {hdr};
    cmp(i_host.cnt, b + nq + 3);
    cmp(i_host.word_q[b], hdr);
    cmp(i_host.word_q[b + 1], crc32(hq));
    foreach (pay[k]) cmp(i_host.word_q[b + 2 + k], pay[k]);
    cmp(i_host.word_q[b + nq + 2], crc32(pay));
    cmp(i_host.last_q[b + nq + 2], 1'h1);
    cmp(i_host.last_q[b + nq + 1], 1'h0);
    cmp(start_ready, 1'h1);
    $display("packet test done");
  endtask
  task automatic t_refuse;
    int b;
    b = i_host.cnt;
    pkt_quads = 13'h0004;
    for (int s = 1; s <= 5; s++) begin
      pulse_start(s[2:0], s[2:0] - 3'h1);
      @(negedge clk);
      cmp(speed_err, 1'h1);
    end
    pkt_quads = 13'h0000;
    pulse_start(3'h1, 3'h5);
    repeat (6) @(negedge clk);
    cmp(speed_err, 1'h0);
    cmp(i_host.cnt, b);
    cmp(start_ready, 1'h1);
    $display("refusal test done");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'h1;
    @(negedge clk);
    t_reset();
    run_pkt(6'h3F, 1'h1, 1, 1'h0, 3'h5, 3'h5);
    run_pkt(6'h05, 1'h0, 9, 1'h1, 3'h2, 3'h3);
    t_refuse();
    run_pkt(6'h12, 1'h1, 2, 1'h0, 3'h0, 3'h1);
    end_sim();
  end
endmodule
